// ==== hw/kmm_menu.sv ====
// Overview of operation
// - local/remote key toggles source, when enabled
// - escape restores view before last confirm
// - jog only from keypad source
// - direction key only from keypad source
// - digit key moves digit; fault reset
// - increment/decrement step mode, item or value
// - run key only from keypad source
// - stop key; terminals honour stop enable
// - dc excitation: run flashes, stop lit
// - five modes drive/quick/advanced/verify/tuning
// - tuning skipped while running or faulted
// - menu enters mode selection, then cycles
// - confirm opens monitor, then setting display
// - run only on drive monitor; drive led
// - power up on drive monitor, selected item
// - drive reference editable only when source zero
// - confirm commits edit, returns to monitor
// - advanced all parameters, quick minimum set
// - verify lists changed parameters, editable
// - verify shows none when nothing changed
`timescale 1ns/1ps
module kmm_menu
	import kmm_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = kmm_pkg::DEBOUNCE_CYC,
	parameter int BLINK_CYCLES    = kmm_pkg::BLINK_CYC
) (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire kmm_pkg::kmm_keys_t        key_raw,
	input  wire logic                      source_key_enable_param,
	input  wire logic                      stop_key_enable_param,
	input  wire logic [3:0]                reference_source_select,
	input  wire logic [kmm_pkg::ITEM_W-1:0] startup_monitor_select,
	input  wire logic                      drive_running,
	input  wire logic                      fault_active,
	input  wire logic                      dc_excite_active,
	input  wire logic [kmm_pkg::ITEM_W-1:0] changed_count,
	input  wire logic [kmm_pkg::VALUE_W-1:0] param_rd_value,
	output kmm_pkg::kmm_view_t             view,
	output kmm_pkg::kmm_cmd_t              cmd,
	output kmm_pkg::kmm_led_t              led,
	output kmm_pkg::kmm_pwr_t              pwr,
	output logic                           verify_none
);
	import kmm_pkg::*;

	// ****************************************
	// reset release
	// ****************************************
	logic rst_q1;
	logic rst_sync_b;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_q1     <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_q1     <= 1'b1;
			rst_sync_b <= rst_q1;
		end
	end

	// ****************************************
	// key events and flash source
	// ****************************************
	kmm_keys_t ev;
	logic      flash;

	kmm_key_filter #(
		.NUM         (NUM_KEYS),
		.HOLD_CYCLES (DEBOUNCE_CYCLES)
	) u_filter (
		.clk        (clk),
		.rst_sync_b (rst_sync_b),
		.raw        (key_raw),
		.press      (ev)
	);

	kmm_blink #(
		.HALF_CYCLES (BLINK_CYCLES)
	) u_blink (
		.clk        (clk),
		.rst_sync_b (rst_sync_b),
		.flash      (flash)
	);

	// ****************************************
	// helpers
	// ****************************************
	function automatic kmm_mode_t next_mode(kmm_mode_t m, logic skip);
		unique case (m)
			MODE_DRIVE:  next_mode = MODE_QUICK;
			MODE_QUICK:  next_mode = MODE_ADV;
			MODE_ADV:    next_mode = MODE_VERIFY;
			MODE_VERIFY: next_mode = skip ? MODE_DRIVE : MODE_TUNE;
			MODE_TUNE:   next_mode = MODE_DRIVE;
			default:     next_mode = MODE_DRIVE;
		endcase
	endfunction : next_mode

	function automatic kmm_mode_t prev_mode(kmm_mode_t m, logic skip);
		unique case (m)
			MODE_DRIVE:  prev_mode = skip ? MODE_VERIFY : MODE_TUNE;
			MODE_QUICK:  prev_mode = MODE_DRIVE;
			MODE_ADV:    prev_mode = MODE_QUICK;
			MODE_VERIFY: prev_mode = MODE_ADV;
			MODE_TUNE:   prev_mode = MODE_VERIFY;
			default:     prev_mode = MODE_DRIVE;
		endcase
	endfunction : prev_mode

	function automatic logic [ITEM_W-1:0] item_count(kmm_mode_t m, logic [ITEM_W-1:0] chg);
		unique case (m)
			MODE_DRIVE:  item_count = ITEM_W'(DRIVE_ITEMS);
			MODE_QUICK:  item_count = ITEM_W'(QUICK_ITEMS);
			MODE_ADV:    item_count = ITEM_W'(ADV_ITEMS);
			MODE_VERIFY: item_count = chg;
			MODE_TUNE:   item_count = ITEM_W'(TUNE_ITEMS);
			default:     item_count = ITEM_W'(DRIVE_ITEMS);
		endcase
	endfunction : item_count

	// ****************************************
	// decode
	// ****************************************
	kmm_view_t next_view;
	kmm_view_t snap;
	logic      booted;

	wire                  in_modesel = (view.disp == DISP_MODESEL);
	wire                  in_mon     = (view.disp == DISP_MONITOR);
	wire                  in_set     = (view.disp == DISP_SETTING);
	wire                  drive_mon  = in_mon && (view.mode == MODE_DRIVE);
	wire                  skip_tune  = drive_running || fault_active;
	wire [ITEM_W-1:0]     items      = item_count(view.mode, changed_count);
	wire                  item_top   = (view.item + 1'b1 >= items);
	wire [ITEM_W-1:0]     item_up    = item_top ? '0 : view.item + 1'b1;
	wire [ITEM_W-1:0]     item_dn    = (view.item == '0) ? ((items == '0) ? '0 : items - 1'b1)
	                                                     : view.item - 1'b1;
	wire [VALUE_W-1:0]    step       = VALUE_W'(1) << {view.digit, 2'b00};
	wire                  menu_go    = ev.menu && !ev.escape;
	wire                  conf_go    = ev.confirm && !ev.menu && !ev.escape;
	wire                  step_go    = !ev.confirm && !ev.menu && !ev.escape;
	wire                  ref_zero   = (reference_source_select == 4'h0);
	wire                  set_ok     = (view.mode == MODE_DRIVE) ? (view.item == '0 && ref_zero)
	                                                             : (items != '0);
	wire                  src_ok     = ev.source && source_key_enable_param;
	wire                  run_ok     = ev.run && cmd.keypad_src && drive_mon;
	wire                  jog_ok     = ev.jog && cmd.keypad_src && drive_mon;
	wire                  dir_ok     = ev.direction && cmd.keypad_src;
	wire                  stop_ok    = ev.stop && (cmd.keypad_src || stop_key_enable_param);
	wire                  freset_ok  = ev.digit && fault_active;
	wire                  digit_ok   = ev.digit && !fault_active && in_set && step_go;
	wire                  commit     = conf_go && in_set;
	wire [ITEM_W-1:0]     boot_item  = (startup_monitor_select < ITEM_W'(DRIVE_ITEMS)) ?
	                                   startup_monitor_select : '0;

	// ****************************************
	// display state machine
	// ****************************************
	always_comb begin
		next_view = view;
		if (!booted) begin
			next_view.item = boot_item;
		end else if (ev.escape) begin
			next_view = snap;
		end else if (menu_go) begin
			if (in_modesel) begin
				next_view.mode = next_mode(view.mode, skip_tune);
			end else begin
				next_view.disp = DISP_MODESEL;
			end
		end else if (conf_go) begin
			unique case (view.disp)
				DISP_MODESEL: begin
					next_view.disp = DISP_MONITOR;
					next_view.item = '0;
				end
				DISP_MONITOR: begin
					if (set_ok) begin
						next_view.disp  = DISP_SETTING;
						next_view.value = param_rd_value;
						next_view.digit = '0;
					end
				end
				DISP_SETTING: next_view.disp = DISP_MONITOR;
				default:      next_view.disp = DISP_MONITOR;
			endcase
		end else if (step_go && (ev.incr != ev.decr)) begin
			unique case (view.disp)
				DISP_MODESEL: next_view.mode  = ev.incr ? next_mode(view.mode, skip_tune)
				                                        : prev_mode(view.mode, skip_tune);
				DISP_MONITOR: next_view.item  = ev.incr ? item_up : item_dn;
				DISP_SETTING: next_view.value = ev.incr ? view.value + step
				                                        : view.value - step;
				default:      next_view.disp  = DISP_MONITOR;
			endcase
		end else if (digit_ok) begin
			next_view.digit = (view.digit == DIGIT_W'(DIGITS - 1)) ? '0 : view.digit + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			view   <= VIEW_RST;
			snap   <= VIEW_RST;
			booted <= 1'b0;
		end else begin
			view   <= next_view;
			snap   <= (conf_go && booted) ? view : snap;
			booted <= 1'b1;
		end
	end

	// ****************************************
	// drive commands
	// ****************************************
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cmd <= CMD_RST;
		end else begin
			cmd.keypad_src  <= src_ok ? !cmd.keypad_src : cmd.keypad_src;
			cmd.run         <= (stop_ok || src_ok) ? 1'b0 : (run_ok ? 1'b1 : cmd.run);
			cmd.jog         <= jog_ok;
			cmd.reverse     <= dir_ok ? !cmd.reverse : cmd.reverse;
			cmd.stop        <= stop_ok;
			cmd.fault_reset <= freset_ok;
		end
	end

	// ****************************************
	// parameter write and indicators
	// ****************************************
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pwr         <= PWR_RST;
			led         <= LED_RST;
			verify_none <= 1'b0;
		end else begin
			pwr.wr        <= commit;
			pwr.mode      <= commit ? view.mode : pwr.mode;
			pwr.item      <= commit ? view.item : pwr.item;
			pwr.value     <= commit ? view.value : pwr.value;
			led.run_led   <= dc_excite_active ? flash : drive_running;
			led.stop_led  <= dc_excite_active || !drive_running;
			led.drive_led <= drive_mon || (in_modesel && view.mode == MODE_DRIVE && flash);
			verify_none   <= (view.mode == MODE_VERIFY) && (changed_count == '0);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	sequence s_excite;
		dc_excite_active ##1 dc_excite_active;
	endsequence

	sequence s_set_confirm;
		in_set && conf_go;
	endsequence

	property p_src_toggle;
		src_ok |=> cmd.keypad_src != $past(cmd.keypad_src);
	endproperty
	a_src_toggle: assert property (p_src_toggle) else $error("source key did not toggle");

	property p_src_locked;
		ev.source && !source_key_enable_param |=> $stable(cmd.keypad_src);
	endproperty
	a_src_locked: assert property (p_src_locked) else $error("disabled source key acted");

	property p_escape;
		booted && ev.escape |=> view == $past(snap);
	endproperty
	a_escape: assert property (p_escape) else $error("escape did not restore view");

	property p_jog;
		ev.jog && !cmd.keypad_src |=> !cmd.jog;
	endproperty
	a_jog: assert property (p_jog) else $error("jog from terminal source");

	property p_dir;
		ev.direction && !cmd.keypad_src |=> $stable(cmd.reverse);
	endproperty
	a_dir: assert property (p_dir) else $error("direction changed from terminals");

	property p_freset;
		freset_ok && !ev.escape && !ev.confirm |=> cmd.fault_reset && $stable(view.digit);
	endproperty
	a_freset: assert property (p_freset) else $error("fault reset not issued");

	property p_item_up;
		booted && in_mon && step_go && ev.incr && !ev.decr && !item_top
			|=> view.item == $past(view.item) + 1'b1;
	endproperty
	a_item_up: assert property (p_item_up) else $error("increment did not step item");

	property p_run_gate;
		$rose(cmd.run) |-> $past(cmd.keypad_src && drive_mon);
	endproperty
	a_run_gate: assert property (p_run_gate) else $error("run accepted out of place");

	property p_stop;
		stop_ok |=> !cmd.run && cmd.stop;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not honoured");

	property p_excite_led;
		s_excite |-> led.stop_led;
	endproperty
	a_excite_led: assert property (p_excite_led) else $error("stop led dark in excitation");

	property p_tune_skip;
		booted && in_modesel && menu_go && skip_tune |=> view.mode != MODE_TUNE;
	endproperty
	a_tune_skip: assert property (p_tune_skip) else $error("tuning offered while busy");

	property p_menu_enter;
		booted && menu_go && !in_modesel |=> view.disp == DISP_MODESEL;
	endproperty
	a_menu_enter: assert property (p_menu_enter) else $error("menu did not enter selection");

	property p_commit;
		booted and s_set_confirm |=> pwr.wr && view.disp == DISP_MONITOR;
	endproperty
	a_commit: assert property (p_commit) else $error("confirm did not commit");

	property p_ref_lock;
		booted && drive_mon && conf_go && !ref_zero |=> view.disp == DISP_MONITOR;
	endproperty
	a_ref_lock: assert property (p_ref_lock) else $error("reference edit not locked");

	property p_none;
		view.mode == MODE_VERIFY && changed_count == '0 |=> verify_none;
	endproperty
	a_none: assert property (p_none) else $error("verify none flag missing");

endmodule : kmm_menu

// ==== hw/kmm_pkg.sv ====
package kmm_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS    = 20;
	localparam int DEBOUNCE_TIME_US = 10000;
	localparam int DEBOUNCE_CYC     = (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLINK_TIME_MS    = 250;
	localparam int BLINK_CYC        = (BLINK_TIME_MS * 1000000) / CLK_PERIOD_NS;

	// ****************************************
	// widths and item counts
	// ****************************************
	localparam int NUM_KEYS    = 11;
	localparam int ITEM_W      = 8;
	localparam int VALUE_W     = 16;
	localparam int DIGIT_W     = 2;
	localparam int DIGITS      = 4;
	localparam int DRIVE_ITEMS = 6;
	localparam int QUICK_ITEMS = 16;
	localparam int ADV_ITEMS   = 200;
	localparam int TUNE_ITEMS  = 6;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic source;
		logic menu;
		logic escape;
		logic jog;
		logic direction;
		logic digit;
		logic incr;
		logic decr;
		logic confirm;
		logic run;
		logic stop;
	} kmm_keys_t;

	typedef enum logic [2:0] {MODE_DRIVE, MODE_QUICK, MODE_ADV, MODE_VERIFY, MODE_TUNE} kmm_mode_t;
	typedef enum logic [1:0] {DISP_MODESEL, DISP_MONITOR, DISP_SETTING} kmm_disp_t;

	typedef struct packed {
		kmm_disp_t            disp;
		kmm_mode_t            mode;
		logic [ITEM_W-1:0]    item;
		logic [VALUE_W-1:0]   value;
		logic [DIGIT_W-1:0]   digit;
	} kmm_view_t;

	typedef struct packed {
		logic keypad_src;
		logic run;
		logic jog;
		logic reverse;
		logic stop;
		logic fault_reset;
	} kmm_cmd_t;

	typedef struct packed {
		logic run_led;
		logic stop_led;
		logic drive_led;
	} kmm_led_t;

	typedef struct packed {
		logic                 wr;
		kmm_mode_t            mode;
		logic [ITEM_W-1:0]    item;
		logic [VALUE_W-1:0]   value;
	} kmm_pwr_t;

	// ****************************************
	// reset values
	// ****************************************
	localparam kmm_view_t VIEW_RST = '{DISP_MONITOR, MODE_DRIVE, 8'h00, 16'h0000, 2'h0};
	localparam kmm_cmd_t  CMD_RST  = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	localparam kmm_led_t  LED_RST  = '{1'b0, 1'b1, 1'b0};
	localparam kmm_pwr_t  PWR_RST  = '{1'b0, MODE_DRIVE, 8'h00, 16'h0000};

endpackage : kmm_pkg

// ==== hw/kmm_key_filter.sv ====
`timescale 1ns/1ps
module kmm_key_filter #(
	parameter int NUM         = 11,
	parameter int HOLD_CYCLES = 500000
) (
	input  wire logic           clk,
	input  wire logic           rst_sync_b,
	input  wire logic [NUM-1:0] raw,
	output logic      [NUM-1:0] press
);
	localparam int CW = $clog2(HOLD_CYCLES + 1);

	initial begin
		if (HOLD_CYCLES < 1 || NUM < 1) $error("kmm_key_filter: bad parameters");
	end

	// ****************************************
	// per key sync, settle and edge
	// ****************************************
	for (genvar i = 0; i < NUM; i++) begin : g_key
		logic [2:0]    sync;
		logic [CW-1:0] cnt;
		logic          level;
		wire           settled = (sync[1] == sync[2]);
		wire           done    = settled && (cnt == CW'(HOLD_CYCLES - 1));

		always_ff @(posedge clk or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				sync     <= 3'h0;
				cnt      <= '0;
				level    <= 1'b0;
				press[i] <= 1'b0;
			end else begin
				sync     <= {sync[1:0], raw[i]};
				cnt      <= !settled ? '0 : (done ? cnt : cnt + 1'b1);
				level    <= done ? sync[2] : level;
				press[i] <= done && sync[2] && !level;
			end
		end

		property p_one_event;
			@(posedge clk) disable iff (!rst_sync_b)
			press[i] |=> !press[i];
		endproperty
		a_one_event: assert property (p_one_event) else $error("key event longer than one cycle");
	end

endmodule : kmm_key_filter

// ==== hw/kmm_blink.sv ====
`timescale 1ns/1ps
module kmm_blink #(
	parameter int HALF_CYCLES = 12500000
) (
	input  wire logic clk,
	input  wire logic rst_sync_b,
	output logic      flash
);
	localparam int CW = $clog2(HALF_CYCLES + 1);

	initial begin
		if (HALF_CYCLES < 1) $error("kmm_blink: bad HALF_CYCLES");
	end

	logic [CW-1:0] cnt;
	wire           wrap = (cnt == CW'(HALF_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cnt   <= '0;
			flash <= 1'b0;
		end else begin
			cnt   <= wrap ? '0 : cnt + 1'b1;
			flash <= wrap ? !flash : flash;
		end
	end

endmodule : kmm_blink

// ==== tb/kmm_operator.sv ====
`timescale 1ns/1ps
module kmm_operator (
	input  wire logic          clk,
	input  wire logic          go,
	input  wire logic [3:0]    key_idx,
	input  wire logic          bounce,
	output kmm_pkg::kmm_keys_t key_raw,
	output logic               busy
);
	import kmm_pkg::*;

	// ****************************************
	// one press: chatter, hold, release
	// ****************************************
	logic [5:0] cnt = 6'h00;
	logic [3:0] sel = 4'h0;
	logic       bnc = 1'b0;
	wire        held = (cnt > 6'h10) && !(bnc && cnt > 6'h1A && cnt[0]);

	assign busy    = (cnt != 6'h00);
	assign key_raw = held ? kmm_keys_t'(11'h001 << sel) : kmm_keys_t'(11'h000);

	always @(posedge clk) begin
		if (go && !busy) begin
			cnt <= 6'h1E;
			sel <= key_idx;
			bnc <= bounce;
		end else if (busy) begin
			cnt <= cnt - 6'h01;
		end
	end
endmodule : kmm_operator

// ==== tb/keypad_mode_menu_controller_test.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module keypad_mode_menu_controller_test;
	import kmm_pkg::*;

	// ****************************************
	// key positions and stimulus
	// ****************************************
	localparam int KS = 10, KM = 9, KE = 8, KJ = 7, KF = 6, KG = 5;
	localparam int KI = 4, KD = 3, KC = 2, KR = 1, KP = 0;
	typedef struct {int k; kmm_disp_t d; kmm_mode_t m; int it;} kmm_row_t;

	logic       clk      = 1'b0;
	logic       rst_b    = 1'b0;
	logic       go       = 1'b0;
	logic       bounce   = 1'b0;
	logic [3:0] key_idx  = 4'h0;
	logic       src_en   = 1'b1;
	logic       stop_en  = 1'b0;
	logic [3:0] ref_sel  = 4'h0;
	logic [7:0] startup  = 8'h03;
	logic       running  = 1'b0;
	logic       fault    = 1'b0;
	logic       dc       = 1'b0;
	logic [7:0] changed  = 8'h05;
	logic [15:0] rd_value = 16'h1234;
	kmm_keys_t  key_raw;
	logic       busy;
	kmm_view_t  view;
	kmm_cmd_t   cmd;
	kmm_led_t   led;
	kmm_pwr_t   pwr;
	logic       verify_none;
	logic [2:0] any1;
	logic [2:0] all1;
	int         miscompares = 0;
	int         n_compared  = 0;
	int         n_jog = 0, n_stop = 0, n_frst = 0, n_wr = 0;

	kmm_row_t rows [11] = '{
		'{KM, DISP_MODESEL, MODE_DRIVE, -1}, '{KM, DISP_MODESEL, MODE_QUICK, -1},
		'{KM, DISP_MODESEL, MODE_ADV, -1}, '{KM, DISP_MODESEL, MODE_VERIFY, -1},
		'{KM, DISP_MODESEL, MODE_TUNE, -1}, '{KM, DISP_MODESEL, MODE_DRIVE, -1},
		'{KC, DISP_MONITOR, MODE_DRIVE, 0}, '{KI, DISP_MONITOR, MODE_DRIVE, 1},
		'{KD, DISP_MONITOR, MODE_DRIVE, 0}, '{KC, DISP_SETTING, MODE_DRIVE, 0},
		'{KI, DISP_SETTING, MODE_DRIVE, 0}};

	always #10 clk = ~clk;

	kmm_menu #(.DEBOUNCE_CYCLES(4), .BLINK_CYCLES(4)) kmm_menu_i (
		.clk(clk), .rst_b(rst_b), .key_raw(key_raw), .source_key_enable_param(src_en),
		.stop_key_enable_param(stop_en), .reference_source_select(ref_sel),
		.startup_monitor_select(startup), .drive_running(running), .fault_active(fault),
		.dc_excite_active(dc), .changed_count(changed), .param_rd_value(rd_value),
		.view(view), .cmd(cmd), .led(led), .pwr(pwr), .verify_none(verify_none));

	kmm_operator kmm_operator_i (
		.clk(clk), .go(go), .key_idx(key_idx), .bounce(bounce), .key_raw(key_raw),
		.busy(busy));

	// ****************************************
	// pulse counters and helpers
	// ****************************************
	always @(posedge clk) begin
		if (cmd.jog === 1'b1) n_jog++;
		if (cmd.stop === 1'b1) n_stop++;
		if (cmd.fault_reset === 1'b1) n_frst++;
		if (pwr.wr === 1'b1) n_wr++;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic press(input int k, input logic b);
		@(posedge clk);
		go      <= 1'b1;
		key_idx <= 4'(k);
		bounce  <= b;
		@(posedge clk);
		go <= 1'b0;
		#1;
		for (int n = 0; n < 100 && busy !== 1'b0; n++) step(1);
		step(2);
	endtask : press

	task automatic watch;
		any1 = 3'b000;
		all1 = 3'b111;
		repeat (16) begin
			step(1);
			any1 = any1 | led;
			all1 = all1 & led;
		end
	endtask : watch

	task automatic wrap_up;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	initial begin
		#400000;
		miscompares++;
		wrap_up();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		step(6);
		`CHK("start disp", DISP_MONITOR, view.disp)
		`CHK("start item", 8'h03, view.item)
		`CHK("stop led", 1'b1, led.stop_led)
		foreach (rows[i]) begin
			press(rows[i].k, 1'b0);
			`CHK("disp", rows[i].d, view.disp)
			`CHK("mode", rows[i].m, view.mode)
			if (rows[i].it >= 0) `CHK("item", 8'(rows[i].it), view.item)
		end
		press(KG, 1'b0);
		press(KI, 1'b0);
		`CHK("digit", 2'h1, view.digit)
		`CHK("value", 16'h1245, view.value)
		press(KC, 1'b0);
		`CHK("writes", 1, n_wr)
		`CHK("wr value", 16'h1245, pwr.value)
		`CHK("after commit", DISP_MONITOR, view.disp)
		press(KE, 1'b0);
		`CHK("escape disp", DISP_SETTING, view.disp)
		`CHK("escape value", 16'h1245, view.value)
		press(KM, 1'b0);
		watch();
		`CHK("drive flash", 2'b10, {any1[0], all1[0]})
		press(KC, 1'b0);
		`CHK("drive led", 1'b1, led.drive_led)
		press(KR, 1'b0);
		`CHK("run", 1'b1, cmd.run)
		press(KF, 1'b0);
		`CHK("reverse", 1'b1, cmd.reverse)
		press(KJ, 1'b0);
		`CHK("jogs", 1, n_jog)
		press(KP, 1'b0);
		`CHK("run off", 1'b0, cmd.run)
		`CHK("stops", 1, n_stop)
		@(posedge clk) {running, dc} <= 2'b11;
		watch();
		`CHK("excite leds", 3'b101, {any1[2], all1[2], all1[1]})
		@(posedge clk) {running, dc} <= 2'b00;
		press(KM, 1'b0);
		press(KR, 1'b0);
		`CHK("run on menu", 1'b0, cmd.run)
		press(KC, 1'b0);
		@(posedge clk) ref_sel <= 4'h1;
		press(KC, 1'b0);
		`CHK("ref locked", DISP_MONITOR, view.disp)
		@(posedge clk) ref_sel <= 4'h0;
		@(posedge clk) src_en <= 1'b0;
		press(KS, 1'b0);
		`CHK("src locked", 1'b1, cmd.keypad_src)
		@(posedge clk) src_en <= 1'b1;
		press(KS, 1'b0);
		`CHK("src toggled", 1'b0, cmd.keypad_src)
		press(KR, 1'b0);
		press(KJ, 1'b0);
		press(KF, 1'b0);
		press(KP, 1'b0);
		`CHK("remote run", 1'b0, cmd.run)
		`CHK("remote jog", 1, n_jog)
		`CHK("remote dir", 1'b1, cmd.reverse)
		`CHK("stop locked", 1, n_stop)
		@(posedge clk) stop_en <= 1'b1;
		press(KP, 1'b0);
		`CHK("stop remote", 2, n_stop)
		press(KS, 1'b0);
		@(posedge clk) fault <= 1'b1;
		press(KG, 1'b0);
		`CHK("fault reset", 1, n_frst)
		press(KM, 1'b0);
		for (int c = 0; c < 2; c++) begin
			@(posedge clk) {running, fault} <= (c == 0) ? 2'b01 : 2'b10;
			for (int j = 0; j < 4; j++) press(KM, 1'b0);
			`CHK("tune skip", MODE_DRIVE, view.mode)
		end
		@(posedge clk) {running, fault, changed} <= 10'h000;
		press(KM, 1'b1);
		`CHK("one event", MODE_QUICK, view.mode)
		press(KM, 1'b0);
		press(KM, 1'b0);
		press(KC, 1'b0);
		`CHK("none flag", 1'b1, verify_none)
		press(KC, 1'b0);
		`CHK("empty list", DISP_MONITOR, view.disp)
		@(posedge clk) changed <= 8'h05;
		step(3);
		`CHK("none clear", 1'b0, verify_none)
		press(KC, 1'b0);
		`CHK("verify edit", DISP_SETTING, view.disp)
		press(KM, 1'b0);
		press(KD, 1'b0);
		`CHK("mode back", MODE_ADV, view.mode)
		press(KC, 1'b0);
		press(KD, 1'b0);
		`CHK("adv wrap", 8'(ADV_ITEMS - 1), view.item)
		press(KC, 1'b0);
		`CHK("adv edit", DISP_SETTING, view.disp)
		@(posedge clk) rst_b <= 1'b0;
		step(3);
		`CHK("reset disp", DISP_MONITOR, view.disp)
		`CHK("reset mode", MODE_DRIVE, view.mode)
		@(posedge clk) rst_b <= 1'b1;
		step(6);
		`CHK("restart item", 8'h03, view.item)
		wrap_up();
	end
endmodule : keypad_mode_menu_controller_test
